// ### pcm_color_mapper.v
// top of the playfield colour mapper: wishbone register file and pixel path
// assumes pixel codes and colour ticks come from logic on ref_clk
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pcm_defines.vh"

module pcm_color_mapper (
  input wire ref_clk,
  input wire reset_n,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [`PCM_ADR_W-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [`PCM_DAT_W-1:0] wb_dat_i,
  output reg [`PCM_DAT_W-1:0] wb_dat_o,
  output reg wb_ack_o,
  input wire colorTick,
  input wire lineStart,
  input wire [3:0] pixelCode,
  input wire [7:0] legacyColor,
  input wire pmActive,
  input wire [7:0] pmColor,
  output reg [7:0] colorOut,
  output reg colorStrobe,
  output reg [1:0] modeOut,
  output reg [5:0] priorityLow
);

  // ****************************************************************
  // register file state
  // ****************************************************************
  reg [7:0] colorReg [0:`PCM_COLOR_COUNT-1];
  reg [7:0] priorityReg;
  wire [`PCM_IDX_W-1:0] regIdx;
  wire reqActive;
  wire wrCommit;
  wire inColorRange;
  wire [`PCM_IDX_W-1:0] colorOffset;
  wire [`PCM_COLOR_FLAT_W-1:0] colorFlat;
  reg [`PCM_DAT_W-1:0] next_readData;
  integer i;

  assign regIdx = wb_adr_i[`PCM_ADR_W-1:2];
  assign reqActive = wb_cyc_i & wb_stb_i;
  assign wrCommit = reqActive & wb_ack_o & wb_we_i & wb_sel_i[0];
  assign inColorRange = (regIdx >= `PCM_IDX_PM0_COLOR) && (regIdx <= `PCM_IDX_BACKDROP_COLOR);
  assign colorOffset = regIdx - `PCM_IDX_PM0_COLOR;

  genvar g;
  generate
    for (g = 0; g < `PCM_COLOR_COUNT; g = g + 1) begin : flatten
      assign colorFlat[g*8 +: 8] = colorReg[g];
    end
  endgenerate

  // ****************************************************************
  // pixel path state
  // ****************************************************************
  reg pixelPhase;
  reg [`PCM_COUNT_W-1:0] pixelCount;
  wire [1:0] mode;
  wire [7:0] resolvedColor;
  wire extended;
  wire phaseNow;
  wire [`PCM_COUNT_W-1:0] countNow;
  wire takePixel;

  assign mode = priorityReg[`PCM_MODE_HI:`PCM_MODE_LO];
  assign extended = (mode != `PCM_MODE_LEGACY);
  assign phaseNow = lineStart ? 1'b0 : pixelPhase;
  assign countNow = lineStart ? {`PCM_COUNT_W{1'b0}} : pixelCount;
  assign takePixel = colorTick & ~phaseNow & (countNow < `PCM_PIXELS_PER_LINE);

  // ****************************************************************
  // wishbone slave
  // ****************************************************************
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= reqActive & ~wb_ack_o;
    end
  end

  always @* begin
    next_readData = {`PCM_DAT_W{1'b0}};
    if (regIdx == `PCM_IDX_PRIORITY) begin
      next_readData[7:0] = priorityReg;
    end else if (regIdx == `PCM_IDX_STATUS) begin
      next_readData[7:0] = colorOut;
      next_readData[`PCM_STAT_MODE_HI:`PCM_STAT_MODE_LO] = mode;
      next_readData[`PCM_STAT_COUNT_HI:`PCM_STAT_COUNT_LO] = pixelCount;
    end
  end

  always @(posedge ref_clk) begin
    if (!reset_n) begin
      wb_dat_o <= {`PCM_DAT_W{1'b0}};
    end else if (reqActive & ~wb_ack_o & ~wb_we_i) begin
      wb_dat_o <= next_readData;
    end
  end

  always @(posedge ref_clk) begin
    if (!reset_n) begin
      for (i = 0; i < `PCM_COLOR_COUNT; i = i + 1) begin
        colorReg[i] <= `PCM_COLOR_RESET;
      end
      priorityReg <= `PCM_PRIORITY_RESET;
    end else if (wrCommit) begin
      if (inColorRange) begin
        colorReg[colorOffset[3:0]] <= wb_dat_i[7:0];
      end else if (regIdx == `PCM_IDX_PRIORITY) begin
        priorityReg <= wb_dat_i[7:0];
      end
    end
  end

  // ****************************************************************
  // mode and priority outputs
  // ****************************************************************
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      modeOut <= `PCM_MODE_LEGACY;
      priorityLow <= 6'h00;
    end else begin
      modeOut <= mode;
      priorityLow <= priorityReg[`PCM_PRIO_LOW_HI:0];
    end
  end

  // ****************************************************************
  // colour resolution
  // ****************************************************************
  pcm_color_resolve resolver (
    .mode(mode),
    .code(pixelCode),
    .colorFlat(colorFlat),
    .legacyColor(legacyColor),
    .color(resolvedColor)
  );

  // ****************************************************************
  // pixel timing
  // ****************************************************************
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      pixelPhase <= 1'b0;
      pixelCount <= {`PCM_COUNT_W{1'b0}};
    end else if (colorTick) begin
      pixelPhase <= ~phaseNow;
      if (takePixel) begin
        pixelCount <= countNow + 7'h01;
      end else begin
        pixelCount <= countNow;
      end
    end else if (lineStart) begin
      pixelPhase <= 1'b0;
      pixelCount <= {`PCM_COUNT_W{1'b0}};
    end
  end

  // ****************************************************************
  // output colour register
  // ****************************************************************
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      colorOut <= 8'h00;
      colorStrobe <= 1'b0;
    end else begin
      colorStrobe <= 1'b0;
      if (colorTick && pmActive) begin
        colorOut <= pmColor;
        colorStrobe <= 1'b1;
      end else if (colorTick && !extended) begin
        colorOut <= resolvedColor;
        colorStrobe <= 1'b1;
      end else if (takePixel) begin
        colorOut <= resolvedColor;
        colorStrobe <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ### pcm_defines.vh
// constants for the playfield colour mapper: register indices, modes, timing
// assumes inclusion by bare name from every design file of the mapper
`ifndef PCM_DEFINES_VH
`define PCM_DEFINES_VH

// ****************************************************************
// bus geometry
// ****************************************************************
`define PCM_ADR_W 18
`define PCM_IDX_W 16
`define PCM_DAT_W 32

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define PCM_IDX_PM0_COLOR 16'hd012
`define PCM_IDX_PM1_COLOR 16'hd013
`define PCM_IDX_PM2_COLOR 16'hd014
`define PCM_IDX_PM3_COLOR 16'hd015
`define PCM_IDX_FIELD0_COLOR 16'hd016
`define PCM_IDX_FIELD1_COLOR 16'hd017
`define PCM_IDX_FIELD2_COLOR 16'hd018
`define PCM_IDX_FIELD3_COLOR 16'hd019
`define PCM_IDX_BACKDROP_COLOR 16'hd01a
`define PCM_IDX_PRIORITY 16'hd01b
`define PCM_IDX_STATUS 16'hd01c

// ****************************************************************
// field layouts and reset values
// ****************************************************************
`define PCM_COLOR_COUNT 9
`define PCM_COLOR_FLAT_W 72
`define PCM_COLOR_RESET 8'h00
`define PCM_PRIORITY_RESET 8'h00
`define PCM_MODE_HI 7
`define PCM_MODE_LO 6
`define PCM_PRIO_LOW_HI 5
`define PCM_STAT_MODE_LO 8
`define PCM_STAT_MODE_HI 9
`define PCM_STAT_COUNT_LO 10
`define PCM_STAT_COUNT_HI 16
`define PCM_LUMA_LSB_MASK 8'hfe

// ****************************************************************
// modes and pixel codes
// ****************************************************************
`define PCM_MODE_LEGACY 2'b00
`define PCM_MODE_LUMA16 2'b01
`define PCM_MODE_NINE 2'b10
`define PCM_MODE_HUE16 2'b11
`define PCM_CODE_BACKDROP 4'h8
`define PCM_CODE_FOLD_MASK 4'h7

// ****************************************************************
// timing
// ****************************************************************
`define PCM_PIXELS_PER_LINE 7'h50
`define PCM_COUNT_W 7

`endif

// ### pcm_color_resolve.v
// combinational colour resolver for one pixel code
// assumes colour registers and mode come from the register file of the mapper
`timescale 1ns/1ps
`default_nettype none
`include "pcm_defines.vh"

module pcm_color_resolve (
  input wire [1:0] mode,
  input wire [3:0] code,
  input wire [`PCM_COLOR_FLAT_W-1:0] colorFlat,
  input wire [7:0] legacyColor,
  output reg [7:0] color
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function [7:0] pickColor;
    input [`PCM_COLOR_FLAT_W-1:0] flat;
    input [3:0] idx;
    begin
      pickColor = flat[{idx, 3'b000} +: 8];
    end
  endfunction

  function [7:0] lumaMask;
    input [1:0] m;
    input [7:0] value;
    begin
      if (m == `PCM_MODE_LUMA16) begin
        lumaMask = value;
      end else begin
        lumaMask = value & `PCM_LUMA_LSB_MASK;
      end
    end
  endfunction

  // ****************************************************************
  // resolution
  // ****************************************************************
  reg [7:0] raw;
  reg [7:0] backdrop;
  reg [3:0] idx;

  always @* begin
    raw = 8'h00;
    idx = 4'h0;
    backdrop = pickColor(colorFlat, `PCM_CODE_BACKDROP);
    case (mode)
      `PCM_MODE_LUMA16: begin
        raw = backdrop | {4'h0, code};
      end
      `PCM_MODE_HUE16: begin
        raw = backdrop | {code, 4'h0};
      end
      `PCM_MODE_NINE: begin
        if (code > `PCM_CODE_BACKDROP) begin
          idx = code & `PCM_CODE_FOLD_MASK;
        end else begin
          idx = code;
        end
        raw = pickColor(colorFlat, idx);
      end
      default: begin
        raw = legacyColor;
      end
    endcase
    color = lumaMask(mode, raw);
  end

endmodule
`default_nettype wire

// ### pcm_chk.sv
// checker for the colour mapper: bus handshake and pixel stream
// assumes a bind onto pcm_color_mapper, one clock ref_clk
`timescale 1ns/1ps
`default_nettype none
module pcm_chk (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [17:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic colorTick,
  input wire logic lineStart,
  input wire logic [3:0] pixelCode,
  input wire logic [7:0] legacyColor,
  input wire logic pmActive,
  input wire logic [7:0] pmColor,
  input wire logic [7:0] colorOut,
  input wire logic colorStrobe,
  input wire logic [1:0] modeOut,
  input wire logic [5:0] priorityLow
);
  // ****
  // properties
  // ****
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  wire [15:0] idx = wb_adr_i[17:2];
  property p_ack_one; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("no ack after request");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_idle; !wb_stb_i |=> !wb_ack_o; endproperty
  a_ack_idle: assert property (p_ack_idle) else $error("ack without request");
  property p_wo_zero;
    wb_ack_o && !wb_we_i && idx >= 16'hd012 && idx <= 16'hd01a |-> wb_dat_o == 32'h0;
  endproperty
  a_wo_zero: assert property (p_wo_zero) else $error("colour register read not zero");
  property p_mode;
    wb_ack_o && wb_we_i && wb_sel_i[0] && idx == 16'hd01b |-> ##2 modeOut == $past(wb_dat_i[7:6], 2);
  endproperty
  a_mode: assert property (p_mode) else $error("mode not taken from priority");
  property p_strobe_cause; colorStrobe |-> $past(colorTick); endproperty
  a_strobe_cause: assert property (p_strobe_cause) else $error("strobe without tick");
  property p_hold; $changed(colorOut) |-> colorStrobe; endproperty
  a_hold: assert property (p_hold) else $error("colour changed without strobe");
  property p_legacy;
    modeOut == 2'b00 && colorTick && !pmActive |=> colorStrobe && colorOut == ($past(legacyColor) & 8'hfe);
  endproperty
  a_legacy: assert property (p_legacy) else $error("legacy colour wrong");
  property p_pm; colorTick && pmActive |=> colorStrobe && colorOut == $past(pmColor); endproperty
  a_pm: assert property (p_pm) else $error("player colour wrong");
endmodule
`default_nettype wire

// ### pcm_pixel_src.sv
// pixel code source standing in for the display list processor
// assumes the mapper clock; a run pulse starts one line of 164 ticks
`timescale 1ns/1ps
`default_nettype none
module pcm_pixel_src (
  input wire logic clk,
  input wire logic rstN,
  input wire logic run,
  input wire logic [3:0] gap,
  input wire logic [3:0] base,
  output logic colorTick,
  output logic lineStart,
  output logic [3:0] pixelCode,
  output logic busy
);
  // ****
  // line generator
  // ****
  logic [7:0] cc;
  logic [3:0] w;
  initial {colorTick, lineStart, pixelCode, busy} = 7'h0;
  always @(posedge clk) begin
    colorTick <= 1'b0;
    lineStart <= 1'b0;
    pixelCode <= pixelCode + 4'h5; // junk between ticks
    if (!rstN) begin
      busy <= 1'b0;
      pixelCode <= 4'h0;
    end else if (!busy) begin
      busy <= run;
      cc <= 8'h0;
      w <= 4'h0;
    end else if (w != 4'h0) begin
      w <= w - 4'h1;
    end else begin
      colorTick <= 1'b1;
      lineStart <= (cc == 8'h0);
      pixelCode <= cc[0] ? ~(base + cc[4:1]) : base + cc[4:1];
      cc <= cc + 8'h1;
      w <= gap;
      busy <= (cc != 8'ha3);
    end
  end
endmodule
`default_nettype wire

// ### test_playfield_color_mapper.sv
// testbench for the colour mapper: bus tasks, pixel reference, verdict
// assumes pcm_pixel_src as pixel source and pcm_chk bound to the top
`timescale 1ns/1ps
`default_nettype none
`include "pcm_defines.vh"
module test_playfield_color_mapper;
  logic ref_clk = 0, reset_n = 0, cyc = 0, stb = 0, we = 0, run = 0, pmEn = 0, ph = 0;
  logic [17:0] adr = 0;
  logic [3:0] sel = 0, gap = 0, base = 0;
  logic [31:0] dat = 0, q;
  logic [7:0] legacy = 8'h37, e, colr [0:8];
  logic [7:0] expq [$];
  logic [1:0] mode = 0;
  logic [6:0] cnt = 0;
  int errors = 0, checks = 0, cycN = 0;
  wire [31:0] wbDat;
  wire wbAck, tick, lnStart, strobe, busy;
  wire [3:0] code;
  wire [7:0] cOut;
  wire [1:0] mOut;
  wire [5:0] pLow;
  wire pmAct = pmEn & (code == 4'hc);
  pcm_color_mapper dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(wbDat), .wb_ack_o(wbAck), .colorTick(tick), .lineStart(lnStart),
    .pixelCode(code), .legacyColor(legacy), .pmActive(pmAct), .pmColor(8'h5b),
    .colorOut(cOut), .colorStrobe(strobe), .modeOut(mOut), .priorityLow(pLow));
  pcm_pixel_src src_u (.clk(ref_clk), .rstN(reset_n), .run(run), .gap(gap), .base(base),
    .colorTick(tick), .lineStart(lnStart), .pixelCode(code), .busy(busy));
  // ****
  // tasks
  // ****
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic wbx(input logic w, input logic [15:0] i, input logic [7:0] d, input logic [3:0] s);
    @(posedge ref_clk);
    {cyc, stb, we, adr, sel, dat} <= {2'b11, w, i, 2'b00, s, 24'h0, d};
    do @(posedge ref_clk); while (wbAck !== 1'b1);
    q = wbDat;
    {cyc, stb, we} <= 3'b000;
  endtask
  task complete_run;
    if (errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  function automatic logic [7:0] resolve(input logic [3:0] c);
    case (mode)
      2'b01: return colr[8] | {4'h0, c};
      2'b11: return (colr[8] | {c, 4'h0}) & 8'hfe;
      default: return colr[c > 4'h8 ? c & 4'h7 : c] & 8'hfe;
    endcase
  endfunction
  // ****
  // reference and timeout
  // ****
  always @(posedge ref_clk) begin
    cycN <= cycN + 1;
    if (cycN == 20000) begin
      errors++;
      complete_run;
    end
    if (reset_n && tick) begin
      if (lnStart) {ph, cnt} = 8'h0;
      if (pmAct) expq.push_back(8'h5b);
      else if (mode == 2'b00) expq.push_back(legacy & 8'hfe);
      else if (!ph && cnt < 7'd80) expq.push_back(resolve(code));
      if (!ph) cnt = cnt + 7'd1;
      ph = ~ph;
    end
    if (strobe === 1'b1) begin
      e = expq.size() > 0 ? expq.pop_front() : 8'hxx;
      chk("colorOut", {24'h0, e}, {24'h0, cOut});
    end
  end
  initial forever #20 ref_clk = ~ref_clk;
  // ****
  // main sequence
  // ****
  initial begin
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    wbx(0, `PCM_IDX_PRIORITY, 0, 4'hf);
    chk("priority", 0, q);
    wbx(1, 16'h0123, 8'hff, 4'h1);
    wbx(0, 16'h0123, 0, 4'hf);
    chk("unmapped", 0, q);
    for (int i = 0; i < 9; i++) begin
      colr[i] = 8'(8'h13 * i + 8'h21);
      wbx(1, `PCM_IDX_PM0_COLOR + 16'(i), colr[i], 4'h1);
      wbx(0, `PCM_IDX_PM0_COLOR + 16'(i), 0, 4'hf);
      chk("colour read", 0, q);
    end
    wbx(1, `PCM_IDX_FIELD0_COLOR, 8'h00, 4'h0);
    for (int m = 0; m < 4; m++) begin
      mode = m[1:0];
      wbx(1, `PCM_IDX_PRIORITY, {mode, 6'h2b}, 4'h1);
      wbx(0, `PCM_IDX_PRIORITY, 0, 4'hf);
      chk("priority", {24'h0, mode, 6'h2b}, q);
      chk("modeOut", {30'h0, mode}, {30'h0, mOut});
      chk("priorityLow", 32'h2b, {26'h0, pLow});
      for (int g = 0; g < 4; g += 3) begin
        {gap, base, pmEn} <= {4'(g), 4'(m), m == 3};
        run <= 1'b1;
        @(posedge ref_clk);
        run <= 1'b0;
        do @(posedge ref_clk); while (busy === 1'b1);
        repeat (3) @(posedge ref_clk);
        chk("pending", 0, expq.size());
        wbx(0, `PCM_IDX_STATUS, 0, 4'hf);
        chk("status", {15'h0, `PCM_PIXELS_PER_LINE, mode, e}, q);
      end
    end
    complete_run;
  end
endmodule
bind pcm_color_mapper pcm_chk chk_u (.ref_clk(ref_clk), .reset_n(reset_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .colorTick(colorTick), .lineStart(lineStart), .pixelCode(pixelCode),
  .legacyColor(legacyColor), .pmActive(pmActive), .pmColor(pmColor), .colorOut(colorOut),
  .colorStrobe(colorStrobe), .modeOut(modeOut), .priorityLow(priorityLow));
`default_nettype wire
